/* inc/csc_pkg.sv */
// Constants and types shared by the capacitive-sense control logic.
package csc_pkg;
  localparam logic [7:0] CSC_CONTROL_ADDR = 8'hB0;
  localparam logic [7:0] CSC_CONTROL_BIT_BASE = 8'hB0;
  localparam logic [7:0] CSC_CONTROL_RESET = 8'h00;
  localparam int CSC_ENABLE_POS = 7;
  localparam int CSC_DONE_POS = 5;
  localparam int CSC_BUSY_POS = 4;
  localparam int CSC_CMP_EN_POS = 3;
  localparam int CSC_EXCEEDED_POS = 0;
  localparam logic [7:0] CSC_UNUSED_MASK = 8'h46;
  localparam logic [2:0] CSC_TRIG_SOFTWARE = 3'h0;
  localparam logic [2:0] CSC_TRIG_ALT_A = 3'h6;
  localparam logic [2:0] CSC_TRIG_ALT_B = 3'h7;
  localparam logic [15:0] CSC_THRESHOLD_RESET = 16'h0000;
  typedef enum logic [0:0] {
    CSC_IDLE,
    CSC_CONVERTING
  } csc_state_t;
endpackage

/* inc/csc_cmp_if.sv */
// Signals between the control logic and the threshold comparator.
`timescale 1ns/1ps
interface csc_cmp_if;
  logic compare_enable;
  logic result_valid;
  logic [15:0] result;
  logic [15:0] threshold;
  logic exceeded;
  modport control (output compare_enable, output result_valid, output result,
    output threshold, input exceeded);
  modport comparator (input compare_enable, input result_valid, input result,
    input threshold, output exceeded);
endinterface

/* verilog/csc_compare.sv */
// Digital comparator that flags a finished result above the threshold.
`timescale 1ns/1ps
module csc_compare (
  input wire logic clock,
  input wire logic reset_n,
  csc_cmp_if.comparator cmp
);
  import csc_pkg::*;

  // The result is judged only while the comparator is enabled.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmp.exceeded <= 1'b0;
    end else begin
      cmp.exceeded <= cmp.result_valid && cmp.compare_enable &&
        (cmp.result > cmp.threshold);
    end
  end
endmodule

/* verilog/csc_control.sv */
// Control register, conversion sequencing and status flags of the capacitive sensor.
`timescale 1ns/1ps
module csc_control (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_value,
  output logic [7:0] sfr_rdata,
  input wire logic [2:0] conversion_trigger_mode,
  input wire logic [7:0] threshold_high_byte,
  input wire logic [7:0] threshold_low_byte,
  input wire logic conv_finish,
  input wire logic [15:0] conv_result,
  output logic sense_unit_enable,
  output logic conv_start,
  output logic conversion_busy,
  output logic conversion_done_flag,
  output logic threshold_compare_enable,
  output logic threshold_exceeded_flag
);
  import csc_pkg::*;

  // Returns the bits touched by a register access.
  function automatic logic [7:0] write_mask(input logic byte_hit, input logic bit_hit,
      input logic [2:0] bit_sel);
    logic [7:0] mask;
    mask = 8'h00;
    if (byte_hit) begin
      mask = 8'hFF;
    end else if (bit_hit) begin
      mask[bit_sel] = 1'b1;
    end
    return mask;
  endfunction

  // True for the trigger modes in which a software write starts a conversion.
  function automatic logic soft_start_mode(input logic [2:0] mode);
    return (mode == CSC_TRIG_SOFTWARE) || (mode == CSC_TRIG_ALT_A) ||
      (mode == CSC_TRIG_ALT_B);
  endfunction

  csc_cmp_if cmp ();
  csc_state_t state;
  logic [2:0] trigger_mode;
  logic byte_hit;
  logic bit_hit;
  logic [7:0] wr_mask;
  logic [7:0] wr_data;
  logic [7:0] control_byte;
  logic start_req;
  logic finish_event;
  logic done_clear;
  logic exceeded_clear;

  // Byte writes at the register address, or bit writes inside its bit range.
  assign byte_hit = sfr_wr && (sfr_addr == CSC_CONTROL_ADDR);
  assign bit_hit = sfr_bit_wr &&
    (sfr_bit_addr[7:3] == CSC_CONTROL_BIT_BASE[7:3]);
  assign wr_mask = write_mask(byte_hit, bit_hit, sfr_bit_addr[2:0]);
  assign wr_data = byte_hit ? sfr_wdata : {8{sfr_bit_value}};

  // Unused bits read zero; nothing ever stores them.
  always_comb begin
    control_byte = CSC_CONTROL_RESET & ~CSC_UNUSED_MASK;
    control_byte[CSC_ENABLE_POS] = sense_unit_enable;
    control_byte[CSC_DONE_POS] = conversion_done_flag;
    control_byte[CSC_BUSY_POS] = conversion_busy;
    control_byte[CSC_CMP_EN_POS] = threshold_compare_enable;
    control_byte[CSC_EXCEEDED_POS] = threshold_exceeded_flag;
  end

  assign start_req = wr_mask[CSC_BUSY_POS] && wr_data[CSC_BUSY_POS] && sense_unit_enable &&
    soft_start_mode(trigger_mode) && (state == CSC_IDLE);
  assign finish_event = conv_finish && (state == CSC_CONVERTING);
  assign done_clear = wr_mask[CSC_DONE_POS] && !wr_data[CSC_DONE_POS];
  assign exceeded_clear = wr_mask[CSC_EXCEEDED_POS] && !wr_data[CSC_EXCEEDED_POS];

  // Trigger mode and threshold are registered from their outside registers.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trigger_mode <= CSC_TRIG_SOFTWARE;
      cmp.threshold <= CSC_THRESHOLD_RESET;
    end else begin
      trigger_mode <= conversion_trigger_mode;
      cmp.threshold <= {threshold_high_byte, threshold_low_byte};
    end
  end

  // Writable control bits.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sense_unit_enable <= CSC_CONTROL_RESET[CSC_ENABLE_POS];
      threshold_compare_enable <= CSC_CONTROL_RESET[CSC_CMP_EN_POS];
    end else begin
      if (wr_mask[CSC_ENABLE_POS]) begin
        sense_unit_enable <= wr_data[CSC_ENABLE_POS];
      end
      if (wr_mask[CSC_CMP_EN_POS]) begin
        threshold_compare_enable <= wr_data[CSC_CMP_EN_POS];
      end
    end
  end

  // Conversion sequence; disabling the unit abandons a running conversion.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= CSC_IDLE;
      conversion_busy <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= start_req;
      case (state)
        CSC_IDLE: begin
          if (start_req) begin
            state <= CSC_CONVERTING;
            conversion_busy <= 1'b1;
          end
        end
        CSC_CONVERTING: begin
          if (!sense_unit_enable || conv_finish) begin
            state <= CSC_IDLE;
            conversion_busy <= 1'b0;
          end
        end
        default: begin
          state <= CSC_IDLE;
          conversion_busy <= 1'b0;
        end
      endcase
    end
  end

  // Sticky flags; a hardware set in the same cycle as a clear wins.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conversion_done_flag <= CSC_CONTROL_RESET[CSC_DONE_POS];
      threshold_exceeded_flag <= CSC_CONTROL_RESET[CSC_EXCEEDED_POS];
    end else begin
      if (finish_event) begin
        conversion_done_flag <= 1'b1;
      end else if (wr_mask[CSC_DONE_POS]) begin
        conversion_done_flag <= wr_data[CSC_DONE_POS];
      end
      if (cmp.exceeded) begin
        threshold_exceeded_flag <= 1'b1;
      end else if (exceeded_clear) begin
        threshold_exceeded_flag <= 1'b0;
      end
    end
  end

  // Read data is registered; other addresses read zero.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= (sfr_rd && (sfr_addr == CSC_CONTROL_ADDR)) ? control_byte : 8'h00;
    end
  end

  // Comparator feed.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmp.compare_enable <= 1'b0;
      cmp.result_valid <= 1'b0;
      cmp.result <= 16'h0000;
    end else begin
      cmp.compare_enable <= threshold_compare_enable;
      cmp.result_valid <= finish_event;
      cmp.result <= conv_result;
    end
  end

  csc_compare u_compare (
    .clock(clock),
    .reset_n(reset_n),
    .cmp(cmp.comparator)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_disabled_unit_idle: assert property (!sense_unit_enable |=> !conversion_busy)
    else $error("Busy while the unit is disabled.");
  a_unused_bits_zero: assert property ((sfr_rdata & CSC_UNUSED_MASK) == 8'h00)
    else $error("Unused control bits read nonzero.");
  a_done_flag_sets: assert property (finish_event |=> conversion_done_flag)
    else $error("Done flag not set after a finished conversion.");
  a_done_flag_sticky: assert property (conversion_done_flag && !done_clear
      |=> conversion_done_flag)
    else $error("Done flag dropped without a software clear.");
  a_busy_follows_start: assert property (start_req |=> conversion_busy && conv_start
      ##1 !conv_start)
    else $error("Start did not raise busy with a one-cycle start pulse.");
  a_start_mode_gate: assert property (conv_start |-> $past(wr_mask[CSC_BUSY_POS]) &&
      $past(soft_start_mode(trigger_mode)))
    else $error("Conversion started without a busy write in a software mode.");
  a_compare_disabled: assert property (finish_event && !threshold_compare_enable &&
      !threshold_exceeded_flag && !cmp.exceeded && !cmp.result_valid
      |-> ##3 !threshold_exceeded_flag)
    else $error("Exceeded flag set with the comparator disabled.");
  a_exceed_sets_flag: assert property (finish_event && threshold_compare_enable &&
      (conv_result > cmp.threshold) |-> ##3 threshold_exceeded_flag)
    else $error("Exceeded flag not set for a result above threshold.");
  a_read_data_value: assert property (sfr_rd && (sfr_addr == CSC_CONTROL_ADDR)
      |=> sfr_rdata == $past(control_byte))
    else $error("Register read returned the wrong value.");
  a_exceed_sticky: assert property (threshold_exceeded_flag && !exceeded_clear
      |=> threshold_exceeded_flag)
    else $error("Exceeded flag dropped without a software clear.");

  c_conversion_done: cover property (start_req ##[1:20] finish_event);
  c_threshold_hit: cover property (cmp.exceeded ##1 threshold_exceeded_flag);
  c_set_beats_clear: cover property (finish_event && done_clear);
  c_bit_start: cover property (bit_hit && start_req);
endmodule

/* testbench/csc_front_model.sv */
// Behavioural analog front end that answers conversion starts after a set delay.
`timescale 1ns/1ps
module csc_front_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic conv_start,
  input wire logic sense_unit_enable,
  input wire logic [15:0] result_value,
  input wire logic [7:0] delay,
  output logic conv_finish,
  output logic [15:0] conv_result
);
  logic [7:0] count;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= 8'h00;
      conv_finish <= 1'b0;
      conv_result <= 16'h0000;
    end else begin
      conv_finish <= 1'b0;
      conv_result <= ~conv_result;
      if (!sense_unit_enable) begin
        count <= 8'h00;
      end else if (conv_start) begin
        count <= delay;
      end else if (count == 8'h01) begin
        count <= 8'h00;
        conv_finish <= 1'b1;
        conv_result <= result_value;
      end else if (count != 8'h00) begin
        count <= count - 8'h01;
      end
    end
  end
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the capacitive-sense control logic.
`timescale 1ns/1ps
module tb_top;
  import csc_pkg::*;
  logic clock, reset_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_value, conv_finish;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, thr_hi, thr_lo, rd;
  logic [2:0] mode;
  logic [15:0] conv_result, res_val;
  logic en, start, busy, done, cmp_en, exc;
  int err_count, compares;
  csc_control dut_u (.clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr), .sfr_bit_value(sfr_bit_value), .sfr_rdata(sfr_rdata),
    .conversion_trigger_mode(mode), .threshold_high_byte(thr_hi),
    .threshold_low_byte(thr_lo), .conv_finish(conv_finish), .conv_result(conv_result),
    .sense_unit_enable(en), .conv_start(start), .conversion_busy(busy),
    .conversion_done_flag(done), .threshold_compare_enable(cmp_en),
    .threshold_exceeded_flag(exc));
  csc_front_model fe_u (.clock(clock), .reset_n(reset_n), .conv_start(start),
    .sense_unit_enable(en), .result_value(res_val), .delay(8'h0C),
    .conv_finish(conv_finish), .conv_result(conv_result));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic byte_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clock);
    sfr_wr <= 1'b0;
    #1;
  endtask
  task automatic byte_rd(input logic [7:0] a);
    @(posedge clock);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1;
    rd = sfr_rdata;
  endtask
  task automatic bit_wr(input logic [2:0] b, input logic v);
    @(posedge clock);
    sfr_bit_wr <= 1'b1;
    sfr_bit_addr <= {5'h16, b};
    sfr_bit_value <= v;
    @(posedge clock);
    sfr_bit_wr <= 1'b0;
    #1;
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset;
    byte_rd(CSC_CONTROL_ADDR);
    check(rd, CSC_CONTROL_RESET);
    check({3'h0, en, busy, done, cmp_en, exc}, 8'h00);
  endtask
  task automatic t_fields;
    mode <= 3'h3;
    byte_wr(8'hB0, 8'hFF);
    byte_wr(8'hB0, 8'hFF);
    byte_rd(8'hB0);
    check(rd, 8'hA8);
    check({7'h0, busy}, 8'h00);
    byte_wr(8'hB1, 8'h00);
    byte_rd(8'hB1);
    check(rd, 8'h00);
    byte_rd(8'hB0);
    check(rd, 8'hA8);
    byte_wr(8'hB0, 8'h00);
    byte_rd(8'hB0);
    check({rd[7:1], en}, 8'h00);
  endtask
  task automatic run_conv(input logic [2:0] m, input logic by_bit, input logic ce,
      input logic [15:0] r, input logic ex);
    int i;
    mode <= m;
    res_val <= r;
    byte_wr(8'hB0, {4'h8, ce, 3'h0});
    if (by_bit) bit_wr(3'h4, 1'b1);
    else byte_wr(8'hB0, {4'h9, ce, 3'h0});
    check({7'h0, busy}, 8'h01);
    check({7'h0, start}, 8'h01);
    bit_wr(3'h4, 1'b0);
    check({7'h0, busy}, 8'h01);
    check({7'h0, start}, 8'h00);
    for (i = 0; i < 100 && done !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check({6'h0, busy, done}, 8'h01);
    repeat (12) @(posedge clock);
    #1;
    check({7'h0, exc}, {7'h0, ex});
    byte_rd(8'hB0);
    check(rd, {4'hA, ce, 2'h0, ex});
    bit_wr(3'h5, 1'b0);
    bit_wr(3'h0, 1'b0);
    check({6'h0, done, exc}, 8'h00);
  endtask
  task automatic t_modes;
    run_conv(CSC_TRIG_SOFTWARE, 1'b0, 1'b1, 16'h1001, 1'b1);
    run_conv(CSC_TRIG_ALT_A, 1'b0, 1'b0, 16'h2000, 1'b0);
    run_conv(CSC_TRIG_ALT_B, 1'b1, 1'b1, 16'h1000, 1'b0);
    thr_hi <= 8'h20;
    run_conv(CSC_TRIG_SOFTWARE, 1'b1, 1'b1, 16'h1FFF, 1'b0);
  endtask
  task automatic t_abort;
    mode <= CSC_TRIG_SOFTWARE;
    byte_wr(8'hB0, 8'h80);
    byte_wr(8'hB0, 8'h90);
    check({7'h0, busy}, 8'h01);
    byte_wr(8'hB0, 8'h00);
    @(posedge clock);
    #1;
    check({6'h0, en, busy}, 8'h00);
    repeat (20) @(posedge clock);
    #1;
    check({7'h0, done}, 8'h00);
  endtask
  initial begin
    err_count = 0;
    compares = 0;
    reset_n = 1'b0;
    {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_value} = 4'h0;
    {sfr_addr, sfr_wdata, sfr_bit_addr} = 24'h000000;
    mode = 3'h0;
    thr_hi = 8'h10;
    thr_lo = 8'h00;
    res_val = 16'h0000;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_reset;
    t_fields;
    t_modes;
    t_abort;
    stop_test;
  end
  initial begin
    #200000;
    err_count++;
    stop_test;
  end
endmodule
